//--- include/rgm_cfg.svh
// timing counts, field positions and encodings of the rgmii receive/transmit link
`ifndef RGM_CFG_SVH
`define RGM_CFG_SVH

`define RGM_CORE_PERIOD_PS  5000
`define RGM_RX_HALF_PS      4000
`define RGM_RX_HALF_CYC     (((`RGM_RX_HALF_PS) / (`RGM_CORE_PERIOD_PS)) < 1 ? 1 : \
                             ((`RGM_RX_HALF_PS) / (`RGM_CORE_PERIOD_PS)))

`define RGM_FC_NIBBLE       4'he
`define RGM_RST_NIBBLE      4'h0

`define RGM_IBS_LINK_BIT    0
`define RGM_IBS_SPEED_LSB   1
`define RGM_IBS_DUPLEX_BIT  3

`define RGM_SPEED_2M5       2'h0
`define RGM_SPEED_25M       2'h1
`define RGM_SPEED_125M      2'h2
`define RGM_SPEED_RSVD      2'h3

`endif

//--- include/rgm_pkg.sv
// types shared by the rgmii link logic
package rgm_pkg;

    typedef enum logic {RGM_PH_RISE, RGM_PH_FALL} rgm_phase_t;

    typedef struct packed {
        logic       clk;
        logic       ctrl;
        logic [3:0] d;
    } rgm_pin_t;

    typedef struct packed {
        logic       valid;
        logic       err;
        logic [7:0] data;
    } rgm_rx_beat_t;

    typedef struct packed {
        logic       duplex;
        logic [1:0] speed;
        logic       link;
    } rgm_link_stat_t;

    typedef struct packed {
        logic       valid;
        logic       err;
        logic       rsvd;
        logic [7:0] data;
    } rgm_tx_beat_t;

    typedef struct packed {
        rgm_phase_t phase;
        logic [3:0] cnt;
        rgm_pin_t   pins;
        logic       neg_ctrl;
        logic [3:0] hi_nib;
        logic       take;
    } rgm_rx_state_t;

    typedef struct packed {
        rgm_pin_t     sync1;
        rgm_pin_t     sync2;
        logic         clk_prev;
        logic         pos_ctrl;
        logic [3:0]   lo_nib;
        rgm_tx_beat_t beat;
    } rgm_tx_state_t;

endpackage

//--- rtl/rgm_phy_mac.sv
// phy side of the reduced gigabit mac link: receive drive and transmit capture
`timescale 1ns/1ps
`default_nettype none
`include "rgm_cfg.svh"

// Behaviour
// [RL1] both link clocks nominally 125 MHz; control sampled on both clock edges; the receive clock here runs at 100 MHz
// [RL2] mac sends data with transmit control high then low
// [RL3] mac control high on both edges marks a transmit error, any nibble
// [RL4] mac idles with control low twice; low then high is reserved
// [RL5] phy sends data with receive control high then low, any nibble
// [RL6] errored received data uses receive control high on both edges
// [RL7] control low then high means false carrier, nibble 1110 only
// [RL8] during receive idle, in-band link status sits on the data lines
// [RL9] status bits 2:1 give clock speed 00, 01, 10; 11 never sent
// [RL10] status bit 0 is link up, bit 3 is duplex
// [RL11] low nibble on rising half, high nibble on falling half
module rgm_phy_mac
    import rgm_pkg::*;
(
    input  wire logic           core_clk,
    input  wire logic           sys_rst,
    input  wire rgm_pin_t       tx_pins,
    output var  rgm_pin_t       rx_pins,
    input  wire rgm_rx_beat_t   rx_beat,
    input  wire logic           rx_false_carrier,
    input  wire rgm_link_stat_t link_stat,
    output var  logic           rx_take,
    output var  rgm_tx_beat_t   tx_beat
);

    localparam logic [3:0] HALF_LAST = 4'(`RGM_RX_HALF_CYC - 1);

    rgm_rx_state_t s_q;
    rgm_rx_state_t s_d;
    logic          adv;
    logic [3:0]    ibs_nib;

    rgm_tx_capture u_tx_capture (
        .core_clk (core_clk),
        .sys_rst  (sys_rst),
        .tx_pins  (tx_pins),
        .tx_beat  (tx_beat)
    );

    // half-period counter; at this clock ratio each half lasts one cycle
    assign adv = (s_q.cnt == HALF_LAST);

    // in-band status nibble, reserved speed code folded to 125 MHz
    always_comb begin
        ibs_nib = `RGM_RST_NIBBLE;
        ibs_nib[`RGM_IBS_LINK_BIT]   = link_stat.link;                    // RL10
        ibs_nib[`RGM_IBS_DUPLEX_BIT] = link_stat.duplex;                  // RL10
        if (link_stat.speed == `RGM_SPEED_RSVD) begin
            ibs_nib[`RGM_IBS_SPEED_LSB +: 2] = `RGM_SPEED_125M;           // RL9
        end else begin
            ibs_nib[`RGM_IBS_SPEED_LSB +: 2] = link_stat.speed;           // RL9
        end
    end

    // one beat per receive clock period: rising half, then falling half
    always_comb begin
        s_d = s_q;
        if (adv) begin
            s_d.cnt = '0;
        end else begin
            s_d.cnt = s_q.cnt + 4'h1;
        end
        if (adv) begin
            unique case (s_q.phase)
                RGM_PH_FALL: begin
                    s_d.phase    = RGM_PH_RISE;
                    s_d.pins.clk = 1'b1;                                  // RL1
                    if (rx_beat.valid) begin
                        s_d.pins.ctrl = 1'b1;                             // RL5
                        s_d.neg_ctrl  = rx_beat.err;                      // RL6
                        s_d.pins.d    = rx_beat.data[3:0];                // RL11
                        s_d.hi_nib    = rx_beat.data[7:4];                // RL11
                    end else if (rx_false_carrier) begin
                        s_d.pins.ctrl = 1'b0;                             // RL7
                        s_d.neg_ctrl  = 1'b1;                             // RL7
                        s_d.pins.d    = `RGM_FC_NIBBLE;                   // RL7
                        s_d.hi_nib    = `RGM_FC_NIBBLE;                   // RL7
                    end else begin
                        s_d.pins.ctrl = 1'b0;                             // RL8
                        s_d.neg_ctrl  = 1'b0;                             // RL8
                        s_d.pins.d    = ibs_nib;                          // RL8
                        s_d.hi_nib    = ibs_nib;                          // RL8
                    end
                end
                RGM_PH_RISE: begin
                    s_d.phase     = RGM_PH_FALL;
                    s_d.pins.clk  = 1'b0;
                    s_d.pins.ctrl = s_q.neg_ctrl;                         // RL1
                    s_d.pins.d    = s_q.hi_nib;                           // RL11
                end
            endcase
        end
        // rx_beat is taken at the edge that ends a cycle with rx_take high
        s_d.take = (s_d.phase == RGM_PH_FALL) && (s_d.cnt == HALF_LAST);
    end

    // reset holds every receive pin low
    always_ff @(posedge core_clk) begin
        if (sys_rst) begin
            s_q.phase    <= RGM_PH_RISE;
            s_q.cnt      <= '0;
            s_q.pins     <= '0;
            s_q.neg_ctrl <= 1'b0;
            s_q.hi_nib   <= `RGM_RST_NIBBLE;
            s_q.take     <= 1'b0;
        end else begin
            s_q <= s_d;
        end
    end

    assign rx_pins = s_q.pins;
    assign rx_take = s_q.take;

    // checks on the receive drive

    a_rxclk_half_period: assert property (@(posedge core_clk) disable iff (sys_rst) // RL1
        $rose(rx_pins.clk) |=> !rx_pins.clk)
        else $error("receive clock high half too long");

    a_rxclk_low_half: assert property (@(posedge core_clk) disable iff (sys_rst) // RL1
        $fell(rx_pins.clk) |=> rx_pins.clk)
        else $error("receive clock low half too long");

    a_rx_data_ctrl: assert property (@(posedge core_clk) disable iff (sys_rst) // RL5
        (rx_take && rx_beat.valid && !rx_beat.err) |=> rx_pins.clk && rx_pins.ctrl ##1 !rx_pins.ctrl)
        else $error("data beat control not high then low");

    a_data_over_fc: assert property (@(posedge core_clk) disable iff (sys_rst) // RL5
        (rx_take && rx_beat.valid && rx_false_carrier) |=> rx_pins.ctrl)
        else $error("false carrier overrode a data beat");

    a_rx_err_ctrl: assert property (@(posedge core_clk) disable iff (sys_rst) // RL6
        (rx_take && rx_beat.valid && rx_beat.err) |=> rx_pins.ctrl [*2])
        else $error("errored beat control not high on both halves");

    a_fc_nibble: assert property (@(posedge core_clk) disable iff (sys_rst) // RL7
        (rx_pins.clk && !rx_pins.ctrl && s_q.neg_ctrl) |-> rx_pins.d == `RGM_FC_NIBBLE
        ##1 (rx_pins.ctrl && rx_pins.d == `RGM_FC_NIBBLE))
        else $error("false carrier with a reserved nibble");

    a_fc_ctrl: assert property (@(posedge core_clk) disable iff (sys_rst) // RL7
        (rx_take && !rx_beat.valid && rx_false_carrier) |=> !rx_pins.ctrl ##1 rx_pins.ctrl)
        else $error("false carrier control not low then high");

    a_idle_status: assert property (@(posedge core_clk) disable iff (sys_rst) // RL8
        (rx_take && !rx_beat.valid && !rx_false_carrier) |=> !rx_pins.ctrl
        && rx_pins.d == $past(ibs_nib) ##1 (!rx_pins.ctrl && rx_pins.d == $past(ibs_nib, 2)))
        else $error("idle halves do not carry in-band status");

    a_status_ctrl_low: assert property (@(posedge core_clk) disable iff (sys_rst) // RL8
        (rx_take && !rx_beat.valid && !rx_false_carrier) |=> !rx_pins.ctrl [*2])
        else $error("status halves with control high");

    a_speed_legal: assert property (@(posedge core_clk) disable iff (sys_rst) // RL9
        (!rx_pins.ctrl && !s_q.neg_ctrl && rx_pins.clk)
        |-> rx_pins.d[`RGM_IBS_SPEED_LSB +: 2] != `RGM_SPEED_RSVD)
        else $error("reserved speed code sent in status");

    a_speed_passed: assert property (@(posedge core_clk) disable iff (sys_rst) // RL9
        (rx_take && !rx_beat.valid && !rx_false_carrier && link_stat.speed != `RGM_SPEED_RSVD)
        |=> rx_pins.d[`RGM_IBS_SPEED_LSB +: 2] == $past(link_stat.speed))
        else $error("status speed code does not follow the input");

    a_speed_folded: assert property (@(posedge core_clk) disable iff (sys_rst) // RL9
        (rx_take && !rx_beat.valid && !rx_false_carrier && link_stat.speed == `RGM_SPEED_RSVD)
        |=> rx_pins.d[`RGM_IBS_SPEED_LSB +: 2] == `RGM_SPEED_125M)
        else $error("reserved speed input not sent as top speed");

    a_link_bit: assert property (@(posedge core_clk) disable iff (sys_rst) // RL10
        (rx_take && !rx_beat.valid && !rx_false_carrier) |=>
        rx_pins.d[`RGM_IBS_LINK_BIT] == $past(link_stat.link)
        && rx_pins.d[`RGM_IBS_DUPLEX_BIT] == $past(link_stat.duplex))
        else $error("status link or duplex bit wrong");

    a_nibble_order: assert property (@(posedge core_clk) disable iff (sys_rst) // RL11
        (rx_take && rx_beat.valid) |=> rx_pins.d == $past(rx_beat.data[3:0])
        ##1 rx_pins.d == $past(rx_beat.data[7:4], 2))
        else $error("byte nibbles out of order");

    a_take_spacing: assert property (@(posedge core_clk) disable iff (sys_rst) // RL1
        rx_take |=> !rx_take)
        else $error("two takes in back-to-back cycles");

    a_take_low_half: assert property (@(posedge core_clk) disable iff (sys_rst) // RL1
        rx_take |-> !rx_pins.clk)
        else $error("beat taken while receive clock high");

    a_take_after_rise: assert property (@(posedge core_clk) disable iff (sys_rst) // RL1
        $rose(rx_pins.clk) |=> rx_take)
        else $error("no take after a rising half");

    // transmit capture as seen from the top
    a_tx_rsvd_alone: assert property (@(posedge core_clk) disable iff (sys_rst) // RL4
        tx_beat.rsvd |-> !tx_beat.valid && !tx_beat.err)
        else $error("reserved transmit pattern flagged as data");

    c_rx_data: cover property (@(posedge core_clk) disable iff (sys_rst)
        rx_take && rx_beat.valid && !rx_beat.err);

    c_rx_err: cover property (@(posedge core_clk) disable iff (sys_rst)
        rx_take && rx_beat.valid && rx_beat.err);

    c_rx_fc: cover property (@(posedge core_clk) disable iff (sys_rst)
        rx_take && !rx_beat.valid && rx_false_carrier);

    c_rx_idle: cover property (@(posedge core_clk) disable iff (sys_rst)
        rx_take && !rx_beat.valid && !rx_false_carrier);

    c_tx_beat: cover property (@(posedge core_clk) disable iff (sys_rst)
        tx_beat.valid ##[1:40] tx_beat.valid);

endmodule // rgm_phy_mac

`default_nettype wire

//--- rtl/rgm_tx_capture.sv
// transmit side: samples the mac's pins on both edges of its clock
`timescale 1ns/1ps
`default_nettype none

module rgm_tx_capture
    import rgm_pkg::*;
(
    input  wire logic         core_clk,
    input  wire logic         sys_rst,
    input  wire rgm_pin_t     tx_pins,
    output var  rgm_tx_beat_t tx_beat
);

    rgm_tx_state_t s_q;
    rgm_tx_state_t s_d;
    logic          rise;
    logic          fall;

    assign rise = s_q.sync2.clk & ~s_q.clk_prev;
    assign fall = ~s_q.sync2.clk & s_q.clk_prev;

    always_comb begin
        s_d          = s_q;
        s_d.sync1    = tx_pins;
        s_d.sync2    = s_q.sync1;
        s_d.clk_prev = s_q.sync2.clk;
        s_d.beat     = '0;
        if (rise) begin
            s_d.pos_ctrl = s_q.sync2.ctrl;   // RL1
            s_d.lo_nib   = s_q.sync2.d;      // RL11
        end
        if (fall) begin
            s_d.beat.valid = s_q.pos_ctrl;                        // RL2
            s_d.beat.err   = s_q.pos_ctrl & s_q.sync2.ctrl;       // RL3
            s_d.beat.rsvd  = ~s_q.pos_ctrl & s_q.sync2.ctrl;      // RL4
            s_d.beat.data  = {s_q.sync2.d, s_q.lo_nib};           // RL11
        end
    end

    always_ff @(posedge core_clk) begin
        if (sys_rst) begin
            s_q <= '0;
        end else begin
            s_q <= s_d;
        end
    end

    assign tx_beat = s_q.beat;

    a_tx_beat_pulse: assert property (@(posedge core_clk) disable iff (sys_rst) // RL2
        tx_beat.valid |=> !tx_beat.valid)
        else $error("transmit beat lasted more than one cycle");

    a_tx_err_valid: assert property (@(posedge core_clk) disable iff (sys_rst) // RL3
        tx_beat.err |-> tx_beat.valid && !tx_beat.rsvd)
        else $error("error beat without a valid beat");

endmodule // rgm_tx_capture

`default_nettype wire

//--- test/rgm_mac_model.sv
// mac-side model: drives the transmit pins from its own 64 ns clock
`timescale 1ns/1ps
`default_nettype none

module rgm_mac_model
    import rgm_pkg::*;
(
    output var rgm_pin_t tx_pins
);
    initial tx_pins = '0;

    // one clock period, data set up 2 ns ahead of each edge; clock parked low after
    task automatic send(input logic pc, input logic nc, input logic [7:0] b);
        tx_pins.ctrl = pc;
        tx_pins.d    = b[3:0];
        #2;
        tx_pins.clk  = 1'b1;
        #30;
        tx_pins.ctrl = nc;
        tx_pins.d    = b[7:4];
        #2;
        tx_pins.clk  = 1'b0;
        #30;
        tx_pins.ctrl = 1'b0;
        tx_pins.d    = ~b[7:4];
    endtask
endmodule // rgm_mac_model
`default_nettype wire

//--- test/tb_rgm_phy_mac.sv
// self-checking bench for the phy side of the rgmii link
`timescale 1ns/1ps
`default_nettype none

module tb_rgm_phy_mac
    import rgm_pkg::*;
;
    logic           core_clk = 1'b0;
    logic           sys_rst  = 1'b1;
    rgm_pin_t       tx_pins;
    rgm_pin_t       rx_pins;
    rgm_rx_beat_t   rx_beat = '0;
    logic           rx_false_carrier = 1'b0;
    rgm_link_stat_t link_stat = '0;
    logic           rx_take;
    rgm_tx_beat_t   tx_beat;
    rgm_tx_beat_t   tx_last = '0;
    int             tx_seen = 0;
    int             cycles = 0;
    int             bad_count = 0;
    int             checked = 0;

    always #2.5 core_clk = ~core_clk;

    rgm_phy_mac i_dut (.core_clk(core_clk), .sys_rst(sys_rst), .tx_pins(tx_pins), .rx_pins(rx_pins),
        .rx_beat(rx_beat), .rx_false_carrier(rx_false_carrier), .link_stat(link_stat),
        .rx_take(rx_take), .tx_beat(tx_beat));
    rgm_mac_model i_mac (.tx_pins(tx_pins));

    task automatic results();
        $display("mismatches %0d, comparisons %0d", bad_count, checked);
        if (bad_count == 0 && checked > 0) begin
            $display("Testbench passed");
        end else begin
            $display("Testbench failed");
        end
        $finish;
    endtask

    task automatic chk(input logic ok, input string msg);
        checked++;
        if (ok !== 1'b1) begin
            $display("[FAIL] %0t %s", $time, msg);
            bad_count++;
        end
    endtask

    // records every transmit pulse with valid or rsvd set; also cuts a hang short
    always @(posedge core_clk) begin
        cycles <= cycles + 1;
        if (tx_beat.valid === 1'b1 || tx_beat.rsvd === 1'b1) begin
            tx_last <= tx_beat;
            tx_seen <= tx_seen + 1;
        end
        if (cycles == 6000) begin
            $display("[FAIL] %0t timeout", $time);
            bad_count++;
            results();
        end
    end

    task automatic rx_case(input rgm_rx_beat_t b, input logic fc, input rgm_link_stat_t st, input logic pc,
        input logic nc, input logic [3:0] lo, input logic [3:0] hi, input string msg);
        int n;
        @(posedge core_clk);
        rx_beat          <= b;
        rx_false_carrier <= fc;
        link_stat        <= st;
        repeat (4) @(posedge core_clk);
        n = 0;
        do begin
            @(posedge core_clk);
            #1;
            n++;
        end while (rx_pins.clk !== 1'b1 && n < 8);
        chk(rx_pins.clk === 1'b1 && rx_take === 1'b0 && rx_pins.ctrl === pc && rx_pins.d === lo, msg);
        @(posedge core_clk);
        #1;
        chk(rx_pins.clk === 1'b0 && rx_take === 1'b1 && rx_pins.ctrl === nc && rx_pins.d === hi, msg);
    endtask

    task automatic tx_case(input logic pc, input logic nc, input logic [7:0] b, input rgm_tx_beat_t e,
        input string msg);
        int n0;
        @(posedge core_clk);
        n0 = tx_seen;
        // pins change clear of the core clock edge
        #2;
        i_mac.send(pc, nc, b);
        repeat (4) @(posedge core_clk);
        if (!e.valid && !e.rsvd) begin
            chk(tx_seen == n0, msg);
        end else begin
            chk(tx_seen == n0 + 1 && tx_last.valid === e.valid && tx_last.err === e.err
                && tx_last.rsvd === e.rsvd && tx_last.data === e.data, msg);
        end
    endtask

    task automatic rx_data();
        rx_case('{1'b1, 1'b0, 8'ha5}, 1'b1, '0, 1'b1, 1'b0, 4'h5, 4'ha, "rx data");
    endtask

    task automatic rx_error();
        rx_case('{1'b1, 1'b1, 8'h3c}, 1'b0, '0, 1'b1, 1'b1, 4'hc, 4'h3, "rx error");
    endtask

    task automatic rx_false_carrier_ind();
        rx_case('0, 1'b1, '0, 1'b0, 1'b1, 4'he, 4'he, "rx false carrier");
    endtask

    task automatic rx_idle_status();
        rgm_link_stat_t st;
        logic [1:0]     sp;
        for (int i = 0; i < 4; i++) begin
            st = '{i[0], i[1:0], ~i[0]};
            sp = (i == 3) ? 2'h2 : i[1:0];
            rx_case('0, 1'b0, st, 1'b0, 1'b0, {st.duplex, sp, st.link},
                {st.duplex, sp, st.link}, "rx idle status");
        end
    endtask

    task automatic tx_data();
        tx_case(1'b1, 1'b0, 8'h5a, '{1'b1, 1'b0, 1'b0, 8'h5a}, "tx data");
    endtask

    task automatic tx_error();
        tx_case(1'b1, 1'b1, 8'hc3, '{1'b1, 1'b1, 1'b0, 8'hc3}, "tx error");
    endtask

    task automatic tx_idle();
        tx_case(1'b0, 1'b0, 8'h77, '0, "tx idle pulse");
    endtask

    task automatic tx_reserved();
        tx_case(1'b0, 1'b1, 8'h12, '{1'b0, 1'b0, 1'b1, 8'h12}, "tx reserved");
    endtask

    initial begin
        repeat (20) @(posedge core_clk);
        chk(rx_pins === '0 && rx_take === 1'b0 && tx_beat === '0, "outputs not quiet in reset");
        sys_rst <= 1'b0;
        rx_data();
        rx_error();
        rx_false_carrier_ind();
        rx_idle_status();
        tx_data();
        tx_error();
        tx_idle();
        tx_reserved();
        results();
    end
endmodule // tb_rgm_phy_mac
`default_nettype wire
